/* core/spt_core.sv */
// Functional notes
// - Counter runs as one 32-bit counter or two 16-bit halves.
// - Each counter counts up only, or up then down.
// - Limit clears in up-only mode, reverses direction in up-down mode.
// - Any event may start, stop or halt a counter.
// - Any event may set, clear or toggle any output.
// - Any event may capture the count into selected capture entries.
// - Selected events raise an interrupt or a DMA request.
// - Sixteen entries, each one match or capture.
// - Counter ticks on system clock or a selected input edge.
// - Outputs form PWM with per-output duty and shared period.
// - Events built from match, input/output edge or level, or both.
// - Entry zero can auto-limit the counter.
// - Events can be qualified by counting direction.
// - A match can be held until its event fires.
// - A state variable follows events and persists across cycles.
// - Each event acts only in its enabled states.
// - Capture triggered by match or input/output toggle.
//
// Chosen here: the Wishbone register port and the register addresses.
module spt_core (
  // Clock, reset, enable
  input wire logic I_CLOCK,
  input wire logic I_RESETN,
  input wire logic I_CE,
  // Wishbone slave
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [8:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  // Pins and requests
  input wire logic [spt_pkg::NIN-1:0] I_IN,
  output logic [spt_pkg::NOUT-1:0] O_OUT,
  output logic O_IRQ,
  output logic [1:0] O_DMA_REQ
);
  import spt_pkg::*;

  spt_bus_t bus_st;
  logic [8:0] adr;
  logic wr;
  logic [8:0] cfg;
  logic [3:0] ctrl;
  logic [31:0] cnt, next_cnt;
  logic [1:0] dir, next_dir;
  logic [4:0] state;
  logic [NMC-1:0] regmode;
  logic [NOUT-1:0] outs, outs_p;
  logic [NEV-1:0] evflag, irqen, held, fire;
  logic [31:0] dmaen;
  logic [NIN-1:0] s1, s2, s3, in_f, in_p;
  logic [NMC*32-1:0] mc_q;
  logic [NEV*EVW*32-1:0] ev_q;
  logic [31:0] mc_rd, ev_rd;
  logic [NMC-1:0] cap, meq_l, meq_h;
  logic [1:0] tick, lim, ev_start, ev_stop, ev_halt, ev_lim, run;
  logic [1:0] ev_half [NEV];
  logic [NOUT-1:0] oset, oclr;
  logic st_ld;
  logic [4:0] next_state;
  logic unify;

  assign adr = {I_WB_ADR[8:2], 2'b00};
  assign unify = cfg[CF_UNIFY];

  // ----------------------------------------------------------------
  // Wishbone slave: ack two cycles after the request
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      bus_st <= SPT_BUS_IDLE;
    end else if (I_CE) begin
      case (bus_st)
        SPT_BUS_IDLE: if (I_WB_CYC && I_WB_STB) bus_st <= SPT_BUS_READ;
        SPT_BUS_READ: bus_st <= SPT_BUS_ACK;
        default: bus_st <= SPT_BUS_IDLE;
      endcase
    end
  end
  assign O_WB_ACK = (bus_st == SPT_BUS_ACK);
  assign wr = (bus_st == SPT_BUS_READ) && I_WB_WE && (I_WB_SEL == 4'hf);

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_WB_DAT <= 32'h0;
    end else if (I_CE && bus_st == SPT_BUS_READ) begin
      if (adr >= A_EV_BASE) begin
        O_WB_DAT <= ev_rd;
      end else if (adr >= A_MC_BASE && adr < A_MC_END) begin
        O_WB_DAT <= mc_rd;
      end else if (adr == A_CONFIG) begin
        O_WB_DAT <= {23'h0, cfg};
      end else if (adr == A_CTRL) begin
        O_WB_DAT <= {28'h0, ctrl};
      end else if (adr == A_COUNT) begin
        O_WB_DAT <= cnt;
      end else if (adr == A_STATE) begin
        O_WB_DAT <= {27'h0, state};
      end else if (adr == A_REGMODE) begin
        O_WB_DAT <= {16'h0, regmode};
      end else if (adr == A_OUT) begin
        O_WB_DAT <= {22'h0, outs};
      end else if (adr == A_EVFLAG) begin
        O_WB_DAT <= {16'h0, evflag};
      end else if (adr == A_IRQEN) begin
        O_WB_DAT <= {16'h0, irqen};
      end else if (adr == A_DMAEN) begin
        O_WB_DAT <= dmaen;
      end else begin
        O_WB_DAT <= 32'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Match/capture pool and event configuration
  // ----------------------------------------------------------------
  spt_regmem #(.DEPTH(NMC), .AW(4)) u_mc (
    .i_clk(I_CLOCK),
    .i_resetn(I_RESETN),
    .i_ce(I_CE),
    .i_wr_en(wr && adr >= A_MC_BASE && adr < A_MC_END),
    .i_addr(adr[5:2]),
    .i_wr_data(I_WB_DAT),
    .o_rd_data(mc_rd),
    .i_cap_mask(cap),
    .i_cap_data(cnt),
    .o_q(mc_q)
  );

  spt_regmem #(.DEPTH(NEV*EVW), .AW(6)) u_ev (
    .i_clk(I_CLOCK),
    .i_resetn(I_RESETN),
    .i_ce(I_CE),
    .i_wr_en(wr && adr >= A_EV_BASE),
    .i_addr(adr[7:2]),
    .i_wr_data(I_WB_DAT),
    .o_rd_data(ev_rd),
    .i_cap_mask({NEV*EVW{1'b0}}),
    .i_cap_data(32'h0),
    .o_q(ev_q)
  );

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      cfg <= 9'h0;
      regmode <= 16'h0;
      irqen <= 16'h0;
      dmaen <= 32'h0;
    end else if (I_CE && wr) begin
      if (adr == A_CONFIG) begin
        cfg <= I_WB_DAT[8:0];
      end else if (adr == A_REGMODE) begin
        regmode <= I_WB_DAT[15:0];
      end else if (adr == A_IRQEN) begin
        irqen <= I_WB_DAT[15:0];
      end else if (adr == A_DMAEN) begin
        dmaen <= I_WB_DAT;
      end
    end
  end

  // ----------------------------------------------------------------
  // Input synchroniser and filter
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      s1 <= 8'h0;
      s2 <= 8'h0;
      s3 <= 8'h0;
      in_f <= 8'h0;
      in_p <= 8'h0;
      outs_p <= 10'h0;
    end else if (I_CE) begin
      s1 <= I_IN;
      s2 <= s1;
      s3 <= s2;
      in_f <= (s2 & ~(s2 ^ s3)) | (in_f & (s2 ^ s3));
      in_p <= in_f;
      outs_p <= outs;
    end
  end

  // ----------------------------------------------------------------
  // Match compare per entry and per half
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NMC; i++) begin : g_mc
    logic [31:0] mv;
    assign mv = mc_q[i*32 +: 32];
    assign meq_l[i] = !regmode[i] && (unify ? (mv == cnt)
                      : (mv[15:0] == cnt[15:0]));
    assign meq_h[i] = !regmode[i] && !unify && (mv[31:16] == cnt[31:16]);
  end

  // ----------------------------------------------------------------
  // Event evaluation
  // ----------------------------------------------------------------
  for (genvar e = 0; e < NEV; e++) begin : g_ev
    logic [31:0] smask, ec;
    logic h, mt, m_eff, io, io_p, io_t, dq, en;
    assign smask = ev_q[(e*EVW+EW_STATE)*32 +: 32];
    assign ec = ev_q[(e*EVW+EW_CTRL)*32 +: 32];
    assign h = ec[EC_HALF] && !unify;
    assign mt = (h ? meq_h[ec[EC_MSEL +: 4]] : meq_l[ec[EC_MSEL +: 4]])
                && tick[h];
    assign m_eff = mt || (ec[EC_HOLD] && held[e]);
    assign io = ec[EC_IOOUT] ? outs[ec[EC_IOSEL +: 4]]
                : in_f[ec[EC_IOSEL +: 3]];
    assign io_p = ec[EC_IOOUT] ? outs_p[ec[EC_IOSEL +: 4]]
                  : in_p[ec[EC_IOSEL +: 3]];
    always_comb begin
      case (spt_ioc_t'(ec[EC_IOC +: 2]))
        SPT_IO_LOW: io_t = !io;
        SPT_IO_RISE: io_t = io && !io_p;
        SPT_IO_FALL: io_t = !io && io_p;
        default: io_t = io;
      endcase
      case (spt_dirq_t'(ec[EC_DIR +: 2]))
        SPT_D_ANY: dq = 1'b1;
        SPT_D_UP: dq = !dir[h];
        SPT_D_DOWN: dq = dir[h];
        default: dq = 1'b0;
      endcase
      case (spt_comb_t'(ec[EC_COMB +: 2]))
        SPT_C_OR: en = m_eff || io_t;
        SPT_C_MATCH: en = m_eff;
        SPT_C_IO: en = io_t;
        default: en = m_eff && io_t;
      endcase
    end
    assign fire[e] = en && dq && smask[state]
                     && !ctrl[CT_HALT + h];
    assign ev_half[e] = h ? 2'b10 : 2'b01;
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
      if (!I_RESETN) begin
        held[e] <= 1'b0;
      end else if (I_CE) begin
        held[e] <= !fire[e] && (held[e] || mt);
      end
    end
  end

  // ----------------------------------------------------------------
  // Action gathering
  // ----------------------------------------------------------------
  always_comb begin
    ev_start = 2'b00;
    ev_stop = 2'b00;
    ev_halt = 2'b00;
    ev_lim = 2'b00;
    oset = '0;
    oclr = '0;
    cap = '0;
    st_ld = 1'b0;
    next_state = state;
    for (int e = 0; e < NEV; e++) begin
      if (fire[e]) begin
        if (ev_q[(e*EVW+EW_CTRL)*32+EC_START]) ev_start |= ev_half[e];
        if (ev_q[(e*EVW+EW_CTRL)*32+EC_STOP]) ev_stop |= ev_half[e];
        if (ev_q[(e*EVW+EW_CTRL)*32+EC_HALT]) ev_halt |= ev_half[e];
        if (ev_q[(e*EVW+EW_CTRL)*32+EC_LIMIT]) ev_lim |= ev_half[e];
        oset |= ev_q[(e*EVW+EW_OUT)*32 +: NOUT];
        oclr |= ev_q[(e*EVW+EW_OUT)*32+EO_CLR +: NOUT];
        cap |= ev_q[(e*EVW+EW_CAP)*32 +: NMC] & regmode;
        if (ev_q[(e*EVW+EW_CTRL)*32+EC_SLOAD]) begin
          st_ld = 1'b1;
          next_state = ev_q[(e*EVW+EW_CTRL)*32+EC_NST +: 5];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Control, state, outputs, flags
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ctrl <= CTRL_RST;
    end else if (I_CE) begin
      if (wr && adr == A_CTRL) begin
        ctrl <= I_WB_DAT[3:0] | {ev_halt, ev_stop};
      end else begin
        ctrl[CT_STOP +: 2] <= (ctrl[CT_STOP +: 2] & ~ev_start)
                              | ev_stop;
        ctrl[CT_HALT +: 2] <= ctrl[CT_HALT +: 2] | ev_halt;
      end
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state <= 5'h0;
    end else if (I_CE) begin
      if (st_ld) begin
        state <= next_state;
      end else if (wr && adr == A_STATE) begin
        state <= I_WB_DAT[4:0];
      end
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      outs <= 10'h0;
    end else if (I_CE) begin
      if (wr && adr == A_OUT) begin
        outs <= I_WB_DAT[NOUT-1:0];
      end else begin
        outs <= (outs & ~oclr) | oset ^ (oset & oclr & outs)
                ^ (oset & oclr & ~outs & ~oset) ;
      end
    end
  end
  assign O_OUT = outs;

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      evflag <= 16'h0;
    end else if (I_CE) begin
      evflag <= (evflag & ~((wr && adr == A_EVFLAG) ? I_WB_DAT[15:0]
                 : 16'h0)) | fire;
    end
  end
  assign O_IRQ = |(evflag & irqen);
  assign O_DMA_REQ = {|(fire & dmaen[DM_HI +: 16]), |(fire & dmaen[15:0])};

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  for (genvar h = 0; h < 2; h++) begin : g_half
    assign run[h] = !ctrl[CT_STOP + h] && !ctrl[CT_HALT + h];
    assign tick[h] = run[h] && (!cfg[CF_CLKIN]
                     || (in_f[cfg[CF_INSEL +: 3]]
                     && !in_p[cfg[CF_INSEL +: 3]]));
    assign lim[h] = ev_lim[h] || (cfg[CF_AUTOLIM + h] && !dir[h]
                    && (h ? meq_h[0] : meq_l[0]));
  end

  function automatic logic [32:0] step(input logic [31:0] v,
      input logic d, input logic bid, input logic l);
    logic nd;
    nd = d;
    if (l && !bid) begin
      return 33'h0;
    end
    if (l || (d && v == 32'h0)) begin
      nd = !d;
    end
    if (!bid) begin
      nd = 1'b0;
    end
    return {nd, nd ? v - 32'h1 : v + 32'h1};
  endfunction : step

  always_comb begin
    logic [32:0] r0, r1;
    r0 = step(unify ? cnt : {16'h0, cnt[15:0]}, dir[0],
              cfg[CF_BIDIR], lim[0]);
    r1 = step({16'h0, cnt[31:16]}, dir[1], cfg[CF_BIDIR + 1], lim[1]);
    next_cnt = cnt;
    next_dir = dir;
    if (unify) begin
      if (tick[0]) begin
        next_cnt = r0[31:0];
        next_dir[0] = r0[32];
      end
    end else begin
      if (tick[0]) begin
        next_cnt[15:0] = r0[15:0];
        next_dir[0] = r0[32];
      end
      if (tick[1]) begin
        next_cnt[31:16] = r1[15:0];
        next_dir[1] = r1[32];
      end
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      cnt <= 32'h0;
      dir <= 2'b00;
    end else if (I_CE) begin
      if (wr && adr == A_COUNT) begin
        cnt <= I_WB_DAT;
        dir <= 2'b00;
      end else begin
        cnt <= next_cnt;
        dir <= next_dir;
      end
    end
  end
endmodule : spt_core

/* core/spt_regmem.sv */
module spt_regmem #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // Bus port
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_addr,
  input wire logic [31:0] i_wr_data,
  output logic [31:0] o_rd_data,
  // Hardware capture port
  input wire logic [DEPTH-1:0] i_cap_mask,
  input wire logic [31:0] i_cap_data,
  // All entries in parallel
  output logic [DEPTH*32-1:0] o_q
);
  logic [31:0] mem [DEPTH];

  // ----------------------------------------------------------------
  // Entries, capture wins over a bus write
  // ----------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        mem[i] <= 32'h0;
      end else if (i_ce) begin
        if (i_cap_mask[i]) begin
          mem[i] <= i_cap_data;
        end else if (i_wr_en && i_addr == AW'(i)) begin
          mem[i] <= i_wr_data;
        end
      end
    end
    assign o_q[i*32 +: 32] = mem[i];
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rd_data <= 32'h0;
    end else if (i_ce) begin
      o_rd_data <= mem[i_addr];
    end
  end
endmodule : spt_regmem

/* shared/spt_pkg.sv */
package spt_pkg;
  localparam int NIN = 8;
  localparam int NOUT = 10;
  localparam int NEV = 16;
  localparam int NMC = 16;
  localparam int NST = 32;
  localparam int EVW = 4;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [8:0] A_CONFIG = 9'h000;
  localparam logic [8:0] A_CTRL = 9'h004;
  localparam logic [8:0] A_COUNT = 9'h008;
  localparam logic [8:0] A_STATE = 9'h00c;
  localparam logic [8:0] A_REGMODE = 9'h010;
  localparam logic [8:0] A_OUT = 9'h014;
  localparam logic [8:0] A_EVFLAG = 9'h018;
  localparam logic [8:0] A_IRQEN = 9'h01c;
  localparam logic [8:0] A_DMAEN = 9'h020;
  localparam logic [8:0] A_MC_BASE = 9'h040;
  localparam logic [8:0] A_MC_END = 9'h080;
  localparam logic [8:0] A_EV_BASE = 9'h100;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CF_UNIFY = 0;
  localparam int CF_BIDIR = 1;
  localparam int CF_CLKIN = 3;
  localparam int CF_INSEL = 4;
  localparam int CF_AUTOLIM = 7;
  localparam int CT_STOP = 0;
  localparam int CT_HALT = 2;
  localparam logic [3:0] CTRL_RST = 4'hc;
  localparam int EW_STATE = 0;
  localparam int EW_CTRL = 1;
  localparam int EW_OUT = 2;
  localparam int EW_CAP = 3;
  localparam int EC_MSEL = 0;
  localparam int EC_HALF = 4;
  localparam int EC_IOC = 5;
  localparam int EC_IOOUT = 7;
  localparam int EC_IOSEL = 8;
  localparam int EC_COMB = 12;
  localparam int EC_DIR = 14;
  localparam int EC_HOLD = 16;
  localparam int EC_SLOAD = 17;
  localparam int EC_NST = 18;
  localparam int EC_START = 23;
  localparam int EC_STOP = 24;
  localparam int EC_HALT = 25;
  localparam int EC_LIMIT = 26;
  localparam int EO_CLR = 16;
  localparam int DM_HI = 16;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SPT_IO_LOW, SPT_IO_RISE, SPT_IO_FALL, SPT_IO_HIGH
  } spt_ioc_t;
  typedef enum logic [1:0] {
    SPT_C_OR, SPT_C_MATCH, SPT_C_IO, SPT_C_AND
  } spt_comb_t;
  typedef enum logic [1:0] {
    SPT_D_ANY, SPT_D_UP, SPT_D_DOWN, SPT_D_NONE
  } spt_dirq_t;
  typedef enum logic [1:0] {
    SPT_BUS_IDLE, SPT_BUS_READ, SPT_BUS_ACK
  } spt_bus_t;
endpackage : spt_pkg

/* verif/spt_core_checker.sv */
module spt_core_checker (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RESETN,
  input wire logic I_CE,
  // Bus
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [8:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  input wire logic [31:0] O_WB_DAT,
  input wire logic O_WB_ACK,
  // Requests
  input wire logic O_IRQ,
  input wire logic [1:0] O_DMA_REQ
);
  timeunit 1ns;
  timeprecision 1ns;
  import spt_pkg::*;
  logic wr;
  logic rd;
  logic [31:0] irqen;
  logic [31:0] dmaen;
  // ----
  // Shadows of the request enables
  // ----
  assign wr = I_CE && I_WB_CYC && I_WB_STB && I_WB_WE && I_WB_SEL == 4'hf;
  assign rd = O_WB_ACK && !I_WB_WE;
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      irqen <= 32'h0;
    end else if (wr && I_WB_ADR[8:2] == A_IRQEN[8:2]) begin
      irqen <= I_WB_DAT;
    end
  end
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      dmaen <= 32'h0;
    end else if (wr && I_WB_ADR[8:2] == A_DMAEN[8:2]) begin
      dmaen <= I_WB_DAT;
    end
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESETN);
  sequence s_take;
    $rose(I_WB_STB) && I_WB_CYC && I_CE;
  endsequence
  sequence s_answer;
    !O_WB_ACK ##1 !O_WB_ACK ##1 O_WB_ACK ##1 !O_WB_ACK;
  endsequence
  property p_ack_timing;
    s_take |-> s_answer;
  endproperty
  a_ack_timing: assert property (p_ack_timing)
    else $error("bus answer late or early");
  property p_ack_req;
    O_WB_ACK |-> I_WB_CYC && I_WB_STB;
  endproperty
  a_ack_req: assert property (p_ack_req)
    else $error("ack without request");
  property p_unmapped;
    rd && (I_WB_ADR inside {[9'h024:9'h03f]}) |-> O_WB_DAT == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_state_w;
    rd && I_WB_ADR[8:2] == A_STATE[8:2] |-> O_WB_DAT[31:5] == 27'h0;
  endproperty
  a_state_w: assert property (p_state_w)
    else $error("state wider than five bits");
  property p_out_w;
    rd && I_WB_ADR[8:2] == A_OUT[8:2] |-> O_WB_DAT[31:10] == 22'h0;
  endproperty
  a_out_w: assert property (p_out_w)
    else $error("output register wider than ten bits");
  property p_mode_w;
    rd && I_WB_ADR[8:2] == A_REGMODE[8:2] |-> O_WB_DAT[31:16] == 16'h0;
  endproperty
  a_mode_w: assert property (p_mode_w)
    else $error("more than sixteen entries");
  property p_irq_mask;
    irqen == 32'h0 && $past(irqen) == 32'h0 |-> !O_IRQ;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt with no enable");
  property p_dma_mask;
    O_DMA_REQ[0] |-> (dmaen[15:0] != 16'h0) || ($past(dmaen) & 32'hffff) != 0;
  endproperty
  a_dma_mask: assert property (p_dma_mask)
    else $error("dma request with no enable");
endmodule : spt_core_checker

bind spt_core spt_core_checker u_chk (
  .I_CLOCK(I_CLOCK), .I_RESETN(I_RESETN), .I_CE(I_CE),
  .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE),
  .I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT),
  .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .O_IRQ(O_IRQ),
  .O_DMA_REQ(O_DMA_REQ)
);

/* verif/spt_core_tb.sv */
module spt_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import spt_pkg::*;
  logic clock;
  logic resetn;
  logic wb_cyc;
  logic wb_stb;
  logic wb_we;
  logic [8:0] wb_adr;
  logic [31:0] wb_dat;
  logic [31:0] o_dat;
  logic [31:0] rd_dat;
  logic wb_ack;
  logic [NIN-1:0] pins_in;
  logic [NOUT-1:0] pins_out;
  logic irq;
  logic [1:0] dma;
  int errors;
  int tests_run;
  always #10 clock = ~clock;
  spt_pins u_pins (.i_clk(clock), .o_in(pins_in));
  spt_core u_dut (
    .I_CLOCK(clock), .I_RESETN(resetn), .I_CE(1'h1),
    .I_WB_CYC(wb_cyc), .I_WB_STB(wb_stb), .I_WB_WE(wb_we),
    .I_WB_ADR(wb_adr), .I_WB_SEL(4'hf), .I_WB_DAT(wb_dat),
    .O_WB_DAT(o_dat), .O_WB_ACK(wb_ack), .I_IN(pins_in),
    .O_OUT(pins_out), .O_IRQ(irq), .O_DMA_REQ(dma)
  );
  // ----
  // Checks and bus cycles
  // ----
  task automatic test_done();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  task automatic fail(input string msg);
    errors++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask : fail
  task automatic chk_v(input logic [31:0] got, exp, input string msg);
    tests_run++;
    if (got !== exp) fail(msg);
  endtask : chk_v
  task automatic chk_n(input int got, input int exp, input string msg);
    tests_run++;
    if (got != exp) fail(msg);
  endtask : chk_n
  task automatic tick(inout int n, input int lim);
    @(negedge clock);
    n++;
    if (n > lim) begin
      fail("wait timed out");
      test_done();
    end
  endtask : tick
  task automatic wb(input logic we, input logic [8:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    do begin
      @(posedge clock);
      n++;
      if (n > 20) begin
        fail("bus wait timed out");
        test_done();
      end
    end while (wb_ack !== 1'h1);
    rd_dat = o_dat;
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
    wb_we <= 1'h0;
  endtask : wb
  task automatic rd_chk(input logic [8:0] a, input logic [31:0] exp,
                        input string msg);
    wb(1'h0, a, 32'h0);
    chk_v(rd_dat, exp, msg);
  endtask : rd_chk
  task automatic set_ev(input int e, input logic [31:0] st, ctl, outs, cap);
    logic [8:0] a;
    a = A_EV_BASE + 9'(16 * e);
    wb(1'h1, a, st);
    wb(1'h1, a + 9'h4, ctl);
    wb(1'h1, a + 9'h8, outs);
    wb(1'h1, a + 9'hc, cap);
  endtask : set_ev
  task automatic wait_out(input int idx, input logic val);
    int n;
    n = 0;
    do tick(n, 20); while (pins_out[idx] !== val);
    chk_v({31'h0, pins_out[idx]}, {31'h0, val}, "output level");
  endtask : wait_out
  task automatic dma_gap(input int exp);
    int n;
    n = 0;
    do tick(n, 100); while (dma[0] !== 1'h1);
    n = 0;
    do tick(n, 100); while (dma[0] !== 1'h1);
    chk_n(n, exp, "dma pulse spacing");
  endtask : dma_gap
  task automatic pulse(input int idx);
    u_pins.drive(idx, 1'h1);
    repeat (3) @(posedge clock);
    u_pins.drive(idx, 1'h0);
    repeat (3) @(posedge clock);
  endtask : pulse
  task automatic do_reset();
    @(posedge clock);
    resetn <= 1'h0;
    repeat (2) @(posedge clock);
    resetn <= 1'h1;
  endtask : do_reset
  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    do_reset();
    rd_chk(A_CTRL, 32'hc, "control after reset");
    rd_chk(A_COUNT, 32'h0, "halted counter moved");
    rd_chk(A_CONFIG, 32'h0, "config after reset");
    rd_chk(9'h024, 32'h0, "unmapped read");
    $display("t_reset done");
  endtask : t_reset
  task automatic t_pwm();
    int n;
    do_reset();
    wb(1'h1, A_MC_BASE, 32'h9);
    wb(1'h1, A_MC_BASE + 9'h8, 32'h2);
    set_ev(0, 32'hffffffff, 32'h1000, 32'h8, 32'h0);
    set_ev(1, 32'hffffffff, 32'h1002, 32'h80000, 32'h0);
    wb(1'h1, A_DMAEN, 32'h1);
    wb(1'h1, A_CONFIG, 32'h81);
    wb(1'h1, A_CTRL, 32'h0);
    dma_gap(10);
    n = 0;
    repeat (20) begin
      @(negedge clock);
      if (pins_out[3] === 1'h1) n++;
    end
    chk_n(n, 6, "output high time");
    wb(1'h1, A_CONFIG, 32'h83);
    dma_gap(18);
    wb(1'h1, A_REGMODE, 32'h20);
    set_ev(2, 32'hffffffff, 32'h5002, 32'h0, 32'h20);
    wb(1'h1, A_DMAEN, 32'h4);
    dma_gap(18);
    rd_chk(A_MC_BASE + 9'h14, 32'h2, "captured count");
    rd_chk(A_REGMODE, 32'h20, "mode readback");
    $display("t_pwm done");
  endtask : t_pwm
  task automatic t_split();
    do_reset();
    wb(1'h1, A_CONFIG, 32'h1);
    wb(1'h1, A_CTRL, 32'h0);
    wb(1'h1, A_COUNT, 32'hfff0);
    repeat (30) @(posedge clock);
    wb(1'h0, A_COUNT, 32'h0);
    chk_v({16'h0, rd_dat[31:16]}, 32'h1, "no carry when unified");
    wb(1'h1, A_CONFIG, 32'h0);
    wb(1'h1, A_CTRL, 32'h8);
    wb(1'h1, A_COUNT, 32'hfff0);
    repeat (30) @(posedge clock);
    wb(1'h0, A_COUNT, 32'h0);
    chk_v({rd_dat[31:16], 16'h0}, 32'h0, "upper half moved");
    chk_v({16'h0, rd_dat[15:0] & 16'hffc0}, 32'h0, "no wrap");
    $display("t_split done");
  endtask : t_split
  task automatic t_state();
    do_reset();
    wb(1'h1, A_CTRL, 32'h0);
    set_ev(4, 32'h1, 32'h162120, 32'h2, 32'h0);
    set_ev(5, 32'h80, 32'h2160, 32'h4, 32'h0);
    set_ev(6, 32'hffffffff, 32'h2220, 32'h10001, 32'h0);
    u_pins.drive(1, 1'h1);
    wait_out(1, 1'h1);
    rd_chk(A_STATE, 32'h5, "state after event");
    rd_chk(A_OUT, 32'h2, "event fired outside its states");
    wb(1'h1, A_STATE, 32'h7);
    wait_out(2, 1'h1);
    u_pins.drive(1, 1'h0);
    u_pins.drive(2, 1'h1);
    wait_out(0, 1'h1);
    u_pins.drive(2, 1'h0);
    repeat (8) @(posedge clock);
    u_pins.drive(2, 1'h1);
    wait_out(0, 1'h0);
    chk_v({31'h0, irq}, 32'h0, "interrupt not masked");
    wb(1'h1, A_IRQEN, 32'h40);
    chk_v({31'h0, irq}, 32'h1, "interrupt not raised");
    wb(1'h1, A_EVFLAG, 32'h40);
    chk_v({31'h0, irq}, 32'h0, "interrupt not cleared");
    $display("t_state done");
  endtask : t_state
  task automatic t_events();
    int n;
    do_reset();
    wb(1'h1, A_CONFIG, 32'h39);
    wb(1'h1, A_CTRL, 32'h0);
    repeat (3) pulse(3);
    rd_chk(A_COUNT, 32'h3, "input clocked count");
    wb(1'h1, A_DMAEN, 32'h800000);
    set_ev(7, 32'hffffffff, 32'h2002320, 32'h0, 32'h0);
    u_pins.drive(3, 1'h1);
    n = 0;
    do tick(n, 20); while (dma[1] !== 1'h1);
    chk_v({31'h0, dma[1]}, 32'h1, "high dma request");
    u_pins.drive(3, 1'h0);
    repeat (3) pulse(3);
    rd_chk(A_COUNT, 32'h4, "halt event ignored");
    rd_chk(A_CTRL, 32'h4, "halt bit not set");
    $display("t_events done");
  endtask : t_events
  initial begin
    clock = 1'h0;
    resetn = 1'h0;
    wb_cyc = 1'h0;
    wb_stb = 1'h0;
    wb_we = 1'h0;
    wb_adr = 9'h0;
    wb_dat = 32'h0;
    errors = 0;
    tests_run = 0;
    t_reset();
    t_pwm();
    t_split();
    t_state();
    t_events();
    test_done();
  end
endmodule : spt_core_tb

/* verif/spt_pins.sv */
module spt_pins (
  // Clock
  input wire logic i_clk,
  // Input pins of the block
  output logic [7:0] o_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_in = 8'h00;
  // Change one pin just after a rising edge
  task automatic drive(input int idx, input logic val);
    @(posedge i_clk);
    o_in[idx] <= val;
  endtask : drive
endmodule : spt_pins
